// file: design/rpat_defs.vh
// Constants for the receive packet aligner and time stamper.
`ifndef RPAT_DEFS_VH
`define RPAT_DEFS_VH
// ----------------------------------------------------------------------------
// Receive modes
// ----------------------------------------------------------------------------
`define RPAT_MODE_FIXED_188     2'h0
`define RPAT_MODE_FIXED_204     2'h1
`define RPAT_MODE_SIZE_ADAPTIVE 2'h2
`define RPAT_MODE_UNFRAMED      2'h3
// ----------------------------------------------------------------------------
// Packet constants
// ----------------------------------------------------------------------------
`define RPAT_SYNC_BYTE          8'h47
`define RPAT_LEN_188            8'hBC
`define RPAT_LEN_204            8'hCC
`define RPAT_STAMP_BYTES        3'h4
`define RPAT_REF_RESET          32'h0000_0000
`endif

// file: design/rpat_skid_buf.v
// Two-entry buffer with valid and ready on both sides.
module rpat_skid_buf #(
    parameter WIDTH = 8
) (
    input  wire             core_clk_i,
    input  wire             rst_b_i,
    input  wire             flush_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [WIDTH-1:0] mem_q [0:1];   // Two entries, addressed by pointer.
    reg             wr_ptr_q;      // Next entry to write.
    reg             rd_ptr_q;      // Next entry to read.
    reg [1:0]       count_q;       // Number of entries held.
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_q != 2'h2);
    assign out_valid_o = (count_q != 2'h0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointers and count; a flush empties the buffer at once.
    always @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else if (flush_i)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Data entries need no reset; count guards their use.
    always @(posedge core_clk_i)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_i;
    end
endmodule // rpat_skid_buf

// file: design/rpat_rx_align.v
// Receive packet aligner with arrival time stamping.
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Sync bytes stored at multiple-of-four positions.
// - First byte marked by in_pkt_start_i after receive starts a packet.
// - Align in 188, 204, adaptive; not unframed.
// - Unframed mode passes bytes without packet boundaries.
// - Adaptive mode may lose alignment on change.
// - Mode change accepted while storing data.
// - Arriving packets discarded during channel reset.
// - Capture counter per packet, insert before it.
// - Live counter value readable by host.
// - Stamps only when enabled and framed mode.
// - Stamp little-endian at 0..3, sync at 4.
// - Data admitted only while receiving.
// - FIFO clear forces control state to idle.
// ----------------------------------------------------------------------------
`include "rpat_defs.vh"
module rpat_rx_align #(
    parameter STAMP_W = 32
) (
    input  wire               core_clk_i,
    input  wire               rst_b_i,
    input  wire               ref_tick_i,      // Reference clock rate, from a pin.
    input  wire [1:0]         rx_mode_i,
    input  wire               arrival_stamp_enable_i,
    input  wire               rx_start_i,      // Pulse: control state to receiving.
    input  wire               rx_stop_i,       // Pulse: control state to idle.
    input  wire               fifo_clear_i,    // Pulse: clear the receive FIFO.
    input  wire               chan_reset_i,    // Level: receive channel reset.
    input  wire               in_valid_i,      // Byte from the stream receiver.
    input  wire [7:0]         in_data_i,
    input  wire               in_pkt_start_i,  // Marks the sync byte of a packet.
    output wire               in_ready_o,
    output wire               out_valid_o,     // Byte toward the receive FIFO.
    output wire [7:0]         out_data_o,
    input  wire               out_ready_i,
    output wire               receiving_o,
    output reg  [STAMP_W-1:0] ref_count_o
);
    // ------------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------------
    localparam [1:0] ST_HUNT  = 2'h0;  // Waiting for a packet start.
    localparam [1:0] ST_STAMP = 2'h1;  // Emitting the four stamp bytes.
    localparam [1:0] ST_DATA  = 2'h2;  // Passing packet bytes.
    localparam [1:0] ST_PAD   = 2'h3;  // Filling up to a word boundary.

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [1:0]          tick_sync_q;   // Two-stage synchroniser for the tick.
    reg                 tick_prev_q;   // Previous synchronised tick level.
    reg                 rcv_q;         // Control state: 1 receiving, 0 idle.
    reg  [1:0]          state_q;
    reg  [1:0]          state_d;
    reg  [1:0]          lane_q;        // Byte position within a 32-bit word.
    reg  [2:0]          stamp_idx_q;   // Stamp byte counter.
    reg  [STAMP_W-1:0]  stamp_q;       // Captured arrival time.
    reg  [7:0]          held_q;        // Sync byte held while the stamp goes out.
    wire                framed;
    wire                stamping;
    wire                flush;
    wire                tick_rise;
    reg                 buf_valid;
    reg  [7:0]          buf_data;
    reg                 take;          // Upstream byte is consumed.
    wire                buf_ready;
    wire                beat;

    assign framed      = (rx_mode_i != `RPAT_MODE_UNFRAMED);
    assign stamping    = arrival_stamp_enable_i & framed;
    assign flush       = chan_reset_i | fifo_clear_i;
    assign tick_rise   = tick_sync_q[1] & ~tick_prev_q;
    assign receiving_o = rcv_q;
    assign beat        = buf_valid & buf_ready;
    // Bytes are drained freely while idle or in reset, so they are discarded.
    assign in_ready_o  = ~rcv_q | chan_reset_i | (take & buf_ready);

    // ------------------------------------------------------------------------
    // Reference counter
    // ------------------------------------------------------------------------
    // The tick comes from another domain, so it passes two flops first.
    always @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_sync_q <= 2'h0;
            tick_prev_q <= 1'b0;
            ref_count_o <= `RPAT_REF_RESET;
        end
        else
        begin
            tick_sync_q <= {tick_sync_q[0], ref_tick_i};
            tick_prev_q <= tick_sync_q[1];
            // Natural overflow wraps to zero without any flag.
            if (tick_rise)
                ref_count_o <= ref_count_o + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    // Clear wins over start, so a clear always leaves the channel idle.
    always @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rcv_q <= 1'b0;
        else if (fifo_clear_i | rx_stop_i)
            rcv_q <= 1'b0;
        else if (rx_start_i)
            rcv_q <= 1'b1;
    end

    // ------------------------------------------------------------------------
    // Byte steering
    // ------------------------------------------------------------------------
    // Chooses which byte goes to the buffer and whether input is consumed.
    always @*
    begin
        buf_valid = 1'b0;
        buf_data  = in_data_i;
        take      = 1'b0;
        state_d   = state_q;
        case (state_q)
            ST_HUNT:
            begin
                if (rcv_q & ~chan_reset_i & in_valid_i)
                begin
                    if (!framed)
                    begin
                        buf_valid = 1'b1;
                        take      = 1'b1;
                    end
                    else if (in_pkt_start_i)
                    begin
                        // Sync byte waits for the stamp or goes out now.
                        if (stamping)
                        begin
                            // Move on only when the buffer has room, so the sync byte
                            // is consumed in the same cycle in which it is captured.
                            take = 1'b1;
                            if (buf_ready)
                                state_d = ST_STAMP;
                        end
                        else
                        begin
                            buf_valid = 1'b1;
                            take      = 1'b1;
                            state_d   = ST_DATA;
                        end
                    end
                    else
                        take = 1'b1;
                end
            end
            ST_STAMP:
            begin
                buf_valid = 1'b1;
                if (stamp_idx_q == `RPAT_STAMP_BYTES)
                begin
                    buf_data = held_q;
                    if (buf_ready)
                        state_d = ST_DATA;
                end
                else
                    buf_data = stamp_q[stamp_idx_q[1:0]*8 +: 8];
            end
            ST_DATA:
            begin
                if (in_valid_i & in_pkt_start_i & (lane_q != 2'h0))
                    state_d = ST_PAD;
                else if (in_valid_i & in_pkt_start_i & stamping)
                    state_d = ST_HUNT;
                else if (in_valid_i)
                begin
                    buf_valid = 1'b1;
                    take      = 1'b1;
                end
            end
            ST_PAD:
            begin
                // Short packets are padded with zeros up to a word boundary.
                buf_valid = 1'b1;
                buf_data  = 8'h00;
                if (buf_ready & (lane_q == 2'h3))
                    state_d = ST_HUNT;
            end
            default:
                state_d = ST_HUNT;
        endcase
        // Nothing enters the buffer once the channel is idle or in reset, even when
        // the sequencer has not yet fallen back to hunting.
        if (!rcv_q | flush)
        begin
            buf_valid = 1'b0;
            take      = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------------
    // A mode change mid-stream is accepted as is; alignment may then slip.
    always @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q     <= ST_HUNT;
            lane_q      <= 2'h0;
            stamp_idx_q <= 3'h0;
            stamp_q     <= `RPAT_REF_RESET;
            held_q      <= 8'h00;
        end
        else if (flush | ~rcv_q)
        begin
            state_q     <= ST_HUNT;
            lane_q      <= 2'h0;
            stamp_idx_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            if (beat)
                lane_q <= lane_q + 2'h1;
            if ((state_q == ST_HUNT) & (state_d == ST_STAMP))
            begin
                stamp_q     <= ref_count_o;
                held_q      <= in_data_i;
                stamp_idx_q <= 3'h0;
            end
            else if ((state_q == ST_STAMP) & beat)
                stamp_idx_q <= stamp_idx_q + 3'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------------------
    rpat_skid_buf #(
        .WIDTH       (8)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .flush_i     (flush),
        .in_valid_i  (buf_valid),
        .in_ready_o  (buf_ready),
        .in_data_i   (buf_data),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_data_o)
    );
endmodule // rpat_rx_align

// file: test/rpat_rx_align_assertions.sv
// Concurrent checks on the ports of the receive packet aligner.
`include "rpat_defs.vh"
module rpat_rx_align_chk #(
    parameter STAMP_W = 32
) (
    input wire               core_clk_i,
    input wire               rst_b_i,
    input wire [1:0]         rx_mode_i,
    input wire               rx_start_i,
    input wire               rx_stop_i,
    input wire               fifo_clear_i,
    input wire               chan_reset_i,
    input wire               in_valid_i,
    input wire               in_ready_o,
    input wire               out_valid_o,
    input wire [7:0]         out_data_o,
    input wire               out_ready_i,
    input wire               receiving_o,
    input wire [STAMP_W-1:0] ref_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Flushes may drop buffered bytes, so they are kept out of the hold checks.
    wire calm = !fifo_clear_i && !chan_reset_i;
    sequence take_s;
        in_valid_i && in_ready_o && receiving_o && calm;
    endsequence
    sequence stall_s;
        out_valid_o && !out_ready_i && calm;
    endsequence
    ref_step_a: assert property ((ref_count_o - $past(ref_count_o)) <= 1)
        else $error("reference counter jumped");
    out_hold_a: assert property (stall_s |=> out_valid_o && $stable(out_data_o))
        else $error("stalled byte changed");
    rx_start_a: assert property (rx_start_i && !rx_stop_i && calm |=> receiving_o)
        else $error("start did not set receiving");
    clear_idle_a: assert property (fifo_clear_i |=> !receiving_o)
        else $error("clear left receiving");
    rx_stop_a: assert property (rx_stop_i && !rx_start_i |=> !receiving_o)
        else $error("stop did not set idle");
    rx_keep_a: assert property (!rx_start_i && !rx_stop_i && calm |=> $stable(receiving_o))
        else $error("control state moved alone");
    idle_drain_a: assert property (!receiving_o || chan_reset_i |-> in_ready_o)
        else $error("input held off while discarding");
    raw_pass_a: assert property (take_s and rx_mode_i == `RPAT_MODE_UNFRAMED |=> out_valid_o)
        else $error("unframed byte not forwarded");
    idle_quiet_a: assert property (!receiving_o && !out_valid_o && calm |=> !out_valid_o)
        else $error("byte stored while idle");
endmodule // rpat_rx_align_chk
bind rpat_rx_align rpat_rx_align_chk #(.STAMP_W(STAMP_W)) chk_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .rx_mode_i(rx_mode_i),
    .rx_start_i(rx_start_i), .rx_stop_i(rx_stop_i), .fifo_clear_i(fifo_clear_i),
    .chan_reset_i(chan_reset_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i),
    .receiving_o(receiving_o), .ref_count_o(ref_count_o));

// file: test/rpat_fifo_model.sv
// Receive FIFO model that takes bytes and stalls at random.
module rpat_fifo_model (
    input  wire core_clk_i,
    input  wire slow_i,
    output reg  ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 32'hb127;
    initial ready_o = 1'b1;
    // Ready moves on the falling edge so it is settled at every sampling edge.
    always @(negedge core_clk_i)
        ready_o <= !slow_i || ($random(seed) % 3 == 0);
endmodule // rpat_fifo_model

// file: test/tb_rx_packet_align_timestamp.sv
// Self-checking bench for the receive packet aligner.
`include "rpat_defs.vh"
module tb_rx_packet_align_timestamp;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_b = 1'b0, tick = 1'b0, stamp_en = 1'b0, slow = 1'b0;
    logic        start = 1'b0, stop = 1'b0, clr = 1'b0, chrst = 1'b0, iv = 1'b0, ps = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  id = 8'h00;
    logic [7:0]  sb;            // Stray byte, kept apart from the driven input.
    wire         ir, ov, ordy, rcv;
    wire [7:0]   od;
    wire [31:0]  rc;
    logic [31:0] ticks = 32'h0;
    logic [7:0]  exp_q[$];
    integer      seed = 32'hb127;
    integer      mismatches = 0, n_checks = 0, cyc = 0, lane = 0;
    always #2.5 clk = ~clk;
    rpat_rx_align dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .ref_tick_i(tick),
        .rx_mode_i(mode), .arrival_stamp_enable_i(stamp_en), .rx_start_i(start),
        .rx_stop_i(stop), .fifo_clear_i(clr), .chan_reset_i(chrst), .in_valid_i(iv),
        .in_data_i(id), .in_pkt_start_i(ps), .in_ready_o(ir), .out_valid_o(ov),
        .out_data_o(od), .out_ready_i(ordy), .receiving_o(rcv), .ref_count_o(rc));
    rpat_fifo_model fifo_u (.core_clk_i(clk), .slow_i(slow), .ready_o(ordy));
    task stop_test;
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A hung handshake ends the run here rather than spinning forever.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            mismatches++;
            stop_test;
        end
    end
    // Every byte the FIFO takes must be the next one expected.
    always @(posedge clk)
        if (rst_b && ov && ordy)
        begin
            if (exp_q.size() == 0)
                chk(od, 32'hFFFF_FFFF);
            else
                chk(od, exp_q.pop_front());
        end
    task pulse(input int which);
        @(negedge clk);
        start = (which == 0);
        stop = (which == 1);
        clr = (which == 2);
        @(negedge clk);
        {start, stop, clr} = 3'h0;
        @(negedge clk);
    endtask
    task put(input logic [7:0] b, input logic s);
        @(negedge clk);
        iv = 1'b1;
        id = b;
        ps = s;
        #1;
        while (ir !== 1'b1)
        begin
            @(negedge clk);
            #1;
        end
        @(posedge clk);
    endtask
    task expect_b(input logic [7:0] b);
        exp_q.push_back(b);
        lane = (lane + 1) % 4;
    endtask
    // Stamp bytes go out least significant first.
    function automatic logic [7:0] stamp_byte(input logic [31:0] t, input int k);
        return t[8*k +: 8];
    endfunction
    // The tick is held still around each packet so the captured stamp is known.
    task tick2;
        @(negedge clk);
        iv = 1'b0;
        tick = 1'b1;
        ticks++;
        repeat (4) @(negedge clk);
        tick = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task pkt(input int n, input bit pass);
        bit         framed;
        logic [7:0] b;
        framed = (mode != `RPAT_MODE_UNFRAMED);
        if (pass && framed)
        begin
            while (lane != 0) expect_b(8'h00);
            if (stamp_en)
                for (int k = 0; k < 4; k++)
                    expect_b(stamp_byte(ticks, k));
        end
        for (int k = 0; k < n; k++)
        begin
            b = (k == 0) ? `RPAT_SYNC_BYTE : $random(seed);
            put(b, k == 0);
            if (pass) expect_b(b);
        end
    endtask
    task drain;
        @(negedge clk);
        iv = 1'b0;
        repeat (3000) if (exp_q.size() != 0) @(negedge clk);
        chk(exp_q.size(), 0);
        repeat (6) @(negedge clk);
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk(rcv, 0);
        chk(rc, 0);
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                pulse(1);
                chrst = 1'b1;
                pkt(8, 0);
                drain;
                chrst = 1'b0;
                mode = m[1:0];
                stamp_en = s[0];
                // Stalls are mixed with stamping and plain runs alike.
                slow = s[0] ^ m[0];
                lane = 0;
                pulse(0);
                chk(rcv, 1);
                // Stray bytes before the first sync must not reach the FIFO in framed modes.
                for (int j = 0; j < 3; j++)
                begin
                    sb = $random(seed);
                    put(sb, 1'b0);
                    if (m == 3) expect_b(sb);
                end
                for (int p = 0; p < 3; p++)
                begin
                    tick2;
                    pkt(m == 0 ? 188 : m == 1 ? 204 : 1 + {$random(seed)} % 9, 1);
                end
                drain;
            end
        pulse(1);
        pkt(6, 0);
        drain;
        pulse(0);
        pulse(2);
        chk(rcv, 0);
        chk(rc, ticks);
        stop_test;
    end
endmodule // tb_rx_packet_align_timestamp
